// [verif/dram_strobe_mask_outputs_tb.sv]
// Purpose: self-checking bench for the strobe and mask outputs
// Assumes: inputs change on the falling edge, pins checked there too
// Notes:   one task per scenario, memory model watches the pins

`timescale 1ns/10ps
`default_nettype none

module dram_strobe_mask_outputs_tb;
    logic                sys_clk = 1'b0;   // 250 MHz clock
    logic                rst     = 1'b1;   // sync reset
    logic                board_cfg2 = 1'b0; // strap
    dsmo_pkg::dsmo_req_t req     = '0;     // request
    logic [7:0]  col_strobe_mask_n;        // lane masks
    logic        dup1_n;                   // lane 1 copy
    logic        dup5_n;                   // lane 5 copy
    logic [2:0]  row_n;                    // row strobes
    logic        dual_pin;                 // dual purpose pin
    logic        col_n;                    // column strobe
    logic [3:0]  we_n;                     // write enables
    logic [13:0] addr;                     // address bus
    logic        cfg2_active;              // latched strap
    logic [2:0]  cmd_seen;                 // model command
    logic [13:0] row_seen;                 // model row
    logic [13:0] col_seen;                 // model column
    int          bad_count = 0;            // mismatches
    int          cmp_count = 0;            // comparisons
    int          cycles    = 0;            // timeout counter

    always #2 sys_clk = ~sys_clk;

    dram_strobe_mask_outputs dut (
        .sys_clk(sys_clk), .rst(rst), .board_cfg2(board_cfg2),
        .req(req), .col_strobe_mask_n(col_strobe_mask_n),
        .col_strobe_mask_lane1_dup_n(dup1_n),
        .col_strobe_mask_lane5_dup_n(dup5_n),
        .sdram_row_strobe_n(row_n), .row_strobe_copy3_n(dual_pin),
        .logical_col_strobe_n(col_n), .write_enable_n(we_n),
        .primary_mem_addr(addr), .cfg2_active(cfg2_active));

    dsmo_sdram_model mem (
        .sys_clk(sys_clk), .row_n(row_n[0]), .col_n(col_n),
        .we_n(we_n[0]), .addr(addr), .cmd_seen(cmd_seen),
        .row_seen(row_seen), .col_seen(col_seen));

    // compare and count
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // final report and end of run
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // build an sdram request
    function automatic dsmo_pkg::dsmo_req_t mk(
        input dsmo_pkg::dsmo_cmd_t c, input logic [13:0] ra,
        input logic [13:0] ca, input logic [7:0] be);
        mk = '0;
        mk.valid = 1'b1;
        mk.cmd = c;
        mk.row_addr = ra;
        mk.col_addr = ca;
        mk.byte_en = be;
    endfunction

    // expected active-low {row,col,we} for a command
    function automatic logic [2:0] enc(input dsmo_pkg::dsmo_cmd_t c);
        case (c)
            dsmo_pkg::DSMO_ACT:   enc = dsmo_pkg::ENC_ACT;
            dsmo_pkg::DSMO_READ:  enc = dsmo_pkg::ENC_READ;
            dsmo_pkg::DSMO_WRITE: enc = dsmo_pkg::ENC_WRITE;
            dsmo_pkg::DSMO_PRE:   enc = dsmo_pkg::ENC_PRE;
            dsmo_pkg::DSMO_REF:   enc = dsmo_pkg::ENC_REF;
            dsmo_pkg::DSMO_MODE:  enc = dsmo_pkg::ENC_MODE;
            default:              enc = dsmo_pkg::ENC_NOP;
        endcase
    endfunction

    // apply a request for one edge, return at the next falling edge
    task automatic step(input dsmo_pkg::dsmo_req_t r);
        req = r;
        @(negedge sys_clk);
    endtask

    // reset with a given strap, then one spare edge
    task automatic do_reset(input logic cfg);
        rst = 1'b1;
        board_cfg2 = cfg;
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask

    // idle pin levels after reset
    task automatic t_reset;
        check("masks", col_strobe_mask_n, 8'hFF);
        check("dups", {dup1_n, dup5_n}, 2'h3);
        check("strobes", {row_n, dual_pin, col_n, we_n}, 9'h1FF);
        check("addr", addr, 14'h0000);
        check("cfg2", cfg2_active, 1'h0);
        $display("test reset done");
    endtask

    // every command, copies, encoding and address multiplexing
    task automatic t_cmds;
        logic [2:0]  e;
        logic [13:0] a;
        a = 14'h0000;
        for (int i = 0; i < 7; i++) begin
            step(mk(dsmo_pkg::dsmo_cmd_t'(i), 14'h2A5A, 14'h15A5, 8'h0F));
            e = enc(dsmo_pkg::dsmo_cmd_t'(i));
            if (i == 1) a = 14'h2A5A;
            if (i == 2 || i == 3) a = 14'h15A5;
            check("enc", {row_n[0], col_n, we_n[0]}, e);
            check("rows", row_n, {3{e[2]}});
            check("dual", dual_pin, e[2]);
            check("wes", we_n, {4{e[0]}});
            check("addr", addr, a);
            check("mask", col_strobe_mask_n,
                  (i == 2 || i == 3) ? 8'hF0 : 8'hFF);
            step('0);
            check("model cmd", cmd_seen, e);
        end
        check("model row", row_seen, 14'h2A5A);
        check("model col", col_seen, 14'h15A5);
        $display("test commands done");
    endtask

    // back-to-back write then read with lane duplicates
    task automatic t_masks;
        step(mk(dsmo_pkg::DSMO_WRITE, 14'h0, 14'h0011, 8'h0F));
        check("wr mask", col_strobe_mask_n, 8'hF0);
        check("wr dups", {dup1_n, dup5_n}, 2'h1);
        step(mk(dsmo_pkg::DSMO_READ, 14'h0, 14'h0022, 8'hA5));
        check("rd mask", col_strobe_mask_n, 8'h5A);
        check("rd dups", {dup1_n, dup5_n}, 2'h2);
        step('0);
        check("idle mask", col_strobe_mask_n, 8'hFF);
        $display("test masks done");
    endtask

    // edo access: lane strobes and write strobe, sdram strobes idle
    task automatic t_edo;
        dsmo_pkg::dsmo_req_t r;
        r = mk(dsmo_pkg::DSMO_WRITE, 14'h0, 14'h0133, 8'h00);
        r.edo_mode = 1'b1;
        r.edo_cas = 8'h3C;
        r.edo_we = 1'b1;
        step(r);
        check("edo cas", col_strobe_mask_n, 8'hC3);
        check("edo dups", {dup1_n, dup5_n}, 2'h2);
        check("edo we", we_n, 4'h0);
        check("edo rc", {row_n, col_n}, 4'hF);
        check("edo addr", addr, 14'h0133);
        step('0);
        $display("test edo done");
    endtask

    // configuration two: dual pin follows bit 5 only when the current or next socket is 0
    task automatic t_cfg2;
        dsmo_pkg::dsmo_req_t r;
        do_reset(1'b1);
        board_cfg2 = 1'b0;
        check("cfg2", cfg2_active, 1'h1);
        step(mk(dsmo_pkg::DSMO_ACT, 14'h0020, 14'h0, 8'h00));
        check("copy s0", dual_pin, 1'h1);
        check("addr s0", addr[5], 1'h1);
        r = mk(dsmo_pkg::DSMO_ACT, 14'h0000, 14'h0, 8'h00);
        r.socket = 2'h1;
        step(r);
        check("copy hold", dual_pin, 1'h1);
        check("addr b5", addr[5], 1'h0);
        r.socket = 2'h2;
        r.next_valid = 1'b1;
        step(r);
        check("copy next", dual_pin, 1'h0);
        step('0);
        check("cfg2 kept", cfg2_active, 1'h1);
        $display("test cfg2 done");
    endtask

    // hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            print_verdict();
        end
    end

    initial begin
        do_reset(1'b0);
        t_reset();
        t_cmds();
        t_masks();
        t_edo();
        t_cfg2();
        print_verdict();
    end
endmodule

`default_nettype wire

// [verif/dsmo_sdram_model.sv]
// Purpose: memory-side view of the strobe and address pins
// Assumes: pins are sampled on the rising sdram clock edge
// Notes:   records the last command and the captured row and column

`timescale 1ns/10ps
`default_nettype none

module dsmo_sdram_model (
    input  wire logic        sys_clk,  // sdram clock
    input  wire logic        row_n,    // row strobe copy 0
    input  wire logic        col_n,    // column strobe
    input  wire logic        we_n,     // write enable copy 0
    input  wire logic [13:0] addr,     // multiplexed address
    output logic      [2:0]  cmd_seen, // last sampled {row,col,we}
    output logic      [13:0] row_seen, // row captured on activate
    output logic      [13:0] col_seen  // column captured on rd/wr
);
    // sample the command triple and latch addresses like a real part
    always @(posedge sys_clk) begin
        cmd_seen <= {row_n, col_n, we_n};
        if (!row_n && col_n && we_n) begin
            row_seen <= addr;
        end
        if (row_n && !col_n) begin
            col_seen <= addr;
        end
    end
endmodule

`default_nettype wire

// [verilog/dram_strobe_mask_outputs.sv]
// Purpose: drives the dram strobe, mask, write enable and address pins
// Assumes: sequencer meets sdram timing; board strap is static
// Notes:   every pin is registered on the same edge so command,
//          address and masks arrive together

`timescale 1ns/10ps
`default_nettype none

module dram_strobe_mask_outputs #(
    parameter int ADDR_W     = dsmo_pkg::ADDR_W,     // address width
    parameter int LANES      = dsmo_pkg::LANES,      // byte lanes
    parameter int RAS_COPIES = dsmo_pkg::RAS_COPIES, // row strobe pins
    parameter int WE_COPIES  = dsmo_pkg::WE_COPIES   // write enable pins
) (
    input  wire logic                sys_clk,                     // clock
    input  wire logic                rst,                         // reset
    input  wire logic                board_cfg2,                  // strap
    input  wire dsmo_pkg::dsmo_req_t req,                         // request
    output logic [LANES-1:0]         col_strobe_mask_n,           // lanes
    output logic                     col_strobe_mask_lane1_dup_n, // dup 1
    output logic                     col_strobe_mask_lane5_dup_n, // dup 5
    output logic [RAS_COPIES-1:0]    sdram_row_strobe_n,          // rows
    output logic                     row_strobe_copy3_n,          // dual
    output logic                     logical_col_strobe_n,        // column
    output logic [WE_COPIES-1:0]     write_enable_n,              // we
    output logic [ADDR_W-1:0]        primary_mem_addr,            // address
    output logic                     cfg2_active                  // strap
);

    // strap capture state
    logic                  cfg_locked;       // strap sampled since reset
    logic                  cfg2;             // latched board configuration

    // command decode wires
    logic                  req_sdram;        // sdram request this cycle
    logic                  is_act;           // activate
    logic                  is_read;          // column read
    logic                  is_write;         // column write
    logic                  is_col;           // any column access
    logic [2:0]            cmd_enc;          // active-low {row,col,we}
    logic                  next_row_n;       // next logical row strobe
    logic                  next_col_n;       // next logical column strobe
    logic                  next_we_n;        // next logical write enable

    // next pin values
    logic [LANES-1:0]      next_mask_n;      // next lane strobe / mask
    logic [ADDR_W-1:0]     next_addr;        // next multiplexed address
    logic                  socket0_hit;      // access touches socket 0

    // registered sources behind the pins
    logic [RAS_COPIES:0]   row_copies_n;     // three pins plus dual copy
    logic                  socket0_bit;      // near-socket address copy

    // strap is caught once, on the first clock after reset release
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cfg_locked <= 1'h0;
            cfg2       <= 1'h0;
        end else if (!cfg_locked) begin
            cfg_locked <= 1'h1;
            cfg2       <= board_cfg2;
        end
    end

    // request qualification
    assign req_sdram = req.valid && !req.edo_mode;
    assign is_act    = req.valid && (req.cmd == dsmo_pkg::DSMO_ACT);
    assign is_read   = req.valid && (req.cmd == dsmo_pkg::DSMO_READ);
    assign is_write  = req.valid && (req.cmd == dsmo_pkg::DSMO_WRITE);
    assign is_col    = is_read || is_write;

    // sdram command to strobe triple
    always_comb begin
        cmd_enc = dsmo_pkg::ENC_NOP;
        if (req_sdram) begin
            unique case (req.cmd)
                dsmo_pkg::DSMO_NOP:   cmd_enc = dsmo_pkg::ENC_NOP;
                dsmo_pkg::DSMO_ACT:   cmd_enc = dsmo_pkg::ENC_ACT;
                dsmo_pkg::DSMO_READ:  cmd_enc = dsmo_pkg::ENC_READ;
                dsmo_pkg::DSMO_WRITE: cmd_enc = dsmo_pkg::ENC_WRITE;
                dsmo_pkg::DSMO_PRE:   cmd_enc = dsmo_pkg::ENC_PRE;
                dsmo_pkg::DSMO_REF:   cmd_enc = dsmo_pkg::ENC_REF;
                dsmo_pkg::DSMO_MODE:  cmd_enc = dsmo_pkg::ENC_MODE;
                default:              cmd_enc = dsmo_pkg::ENC_NOP;
            endcase
        end
    end

    // split triple; edo rows drive the write strobe directly
    assign next_row_n = cmd_enc[2];
    assign next_col_n = cmd_enc[1];
    assign next_we_n  = (req.valid && req.edo_mode) ? !req.edo_we
                                                    : cmd_enc[0];

    // lane pins: edo column strobes or sdram data masks
    assign next_mask_n =
        (req.valid && req.edo_mode) ? ~req.edo_cas :
        (req_sdram && is_read)      ? ~req.byte_en :
        (req_sdram && is_write)     ? ~req.byte_en :
                                      dsmo_pkg::RST_MASK;

    // row address with activate, column with rd/wr, else hold
    assign next_addr = is_act ? req.row_addr :
                       is_col ? req.col_addr :
                                primary_mem_addr;

    // near-socket copy moves for current or next socket 0 access
    assign socket0_hit = cfg2 && req.valid &&
                         ((req.socket == dsmo_pkg::SOCKET0) ||
                          (req.next_valid &&
                           (req.next_socket == dsmo_pkg::SOCKET0)));

    // lane masks, duplicates, column strobe and address share one edge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            col_strobe_mask_n           <= dsmo_pkg::RST_MASK;
            col_strobe_mask_lane1_dup_n <= dsmo_pkg::RST_STROBE;
            col_strobe_mask_lane5_dup_n <= dsmo_pkg::RST_STROBE;
            logical_col_strobe_n        <= dsmo_pkg::RST_STROBE;
            primary_mem_addr            <= dsmo_pkg::RST_ADDR;
        end else begin
            col_strobe_mask_n           <= next_mask_n;
            col_strobe_mask_lane1_dup_n <=
                next_mask_n[dsmo_pkg::DUP_LANE_A];
            col_strobe_mask_lane5_dup_n <=
                next_mask_n[dsmo_pkg::DUP_LANE_B];
            logical_col_strobe_n        <= next_col_n;
            primary_mem_addr            <= next_addr;
        end
    end

    // row strobe onto three pins plus the dual-purpose copy
    dsmo_replicate #(
        .COPIES  (RAS_COPIES + 1),
        .RST_VAL (dsmo_pkg::RST_STROBE)
    ) u_row_copies (
        .sys_clk (sys_clk),
        .rst     (rst),
        .d       (next_row_n),
        .q       (row_copies_n)
    );

    // write enable onto its load-sharing pins
    dsmo_replicate #(
        .COPIES  (WE_COPIES),
        .RST_VAL (dsmo_pkg::RST_STROBE)
    ) u_we_copies (
        .sys_clk (sys_clk),
        .rst     (rst),
        .d       (next_we_n),
        .q       (write_enable_n)
    );

    // near-socket address bit, loaded from the same next address bit
    dsmo_socket_copy u_socket0_bit (
        .sys_clk (sys_clk),
        .rst     (rst),
        .en      (socket0_hit),
        .d       (next_addr[dsmo_pkg::COPY_BIT]),
        .q       (socket0_bit)
    );

    // pin outputs; dual pin selects between two registered sources
    assign sdram_row_strobe_n = row_copies_n[RAS_COPIES-1:0];
    assign row_strobe_copy3_n =
        cfg2 ? socket0_bit
             : row_copies_n[RAS_COPIES];
    assign cfg2_active = cfg2;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------

    // sdram activate request
    sequence s_sdram_act;
        req_sdram && (req.cmd == dsmo_pkg::DSMO_ACT);
    endsequence

    // sdram write request
    sequence s_sdram_write;
        req_sdram && (req.cmd == dsmo_pkg::DSMO_WRITE);
    endsequence

    // sdram read request
    sequence s_sdram_read;
        req_sdram && (req.cmd == dsmo_pkg::DSMO_READ);
    endsequence

    // edo request
    sequence s_edo_req;
        req.valid && req.edo_mode;
    endsequence

    a_act_encode: assert property (
        @(posedge sys_clk) disable iff (rst)
        s_sdram_act |=> (sdram_row_strobe_n[0] == 1'h0) &&
                         logical_col_strobe_n &&
                         write_enable_n[0])
        else $error("activate not encoded as row strobe only");

    a_row_addr_valid: assert property (
        @(posedge sys_clk) disable iff (rst)
        s_sdram_act |=> (primary_mem_addr == $past(req.row_addr)))
        else $error("row address missing with row strobe");

    a_col_addr_valid: assert property (
        @(posedge sys_clk) disable iff (rst)
        (s_sdram_read or s_sdram_write) |=>
            !logical_col_strobe_n &&
            (primary_mem_addr == $past(req.col_addr)))
        else $error("column address missing with column strobe");

    a_write_mask: assert property (
        @(posedge sys_clk) disable iff (rst)
        s_sdram_write |=> (col_strobe_mask_n == ~$past(req.byte_en)) &&
                           (write_enable_n == '0))
        else $error("write mask not aligned with write");

    a_read_mask: assert property (
        @(posedge sys_clk) disable iff (rst)
        s_sdram_read |=> (col_strobe_mask_n == ~$past(req.byte_en)) &&
                          (write_enable_n == '1))
        else $error("read output enables wrong");

    a_edo_strobes: assert property (
        @(posedge sys_clk) disable iff (rst)
        s_edo_req |=> (col_strobe_mask_n == ~$past(req.edo_cas)) &&
                       sdram_row_strobe_n[0])
        else $error("edo column strobes wrong");

    a_lane1_dup: assert property (
        @(posedge sys_clk) disable iff (rst)
        col_strobe_mask_lane1_dup_n ==
            col_strobe_mask_n[dsmo_pkg::DUP_LANE_A])
        else $error("lane one duplicate differs");

    a_lane5_dup: assert property (
        @(posedge sys_clk) disable iff (rst)
        col_strobe_mask_lane5_dup_n ==
            col_strobe_mask_n[dsmo_pkg::DUP_LANE_B])
        else $error("lane five duplicate differs");

    a_dual_cfg1: assert property (
        @(posedge sys_clk) disable iff (rst)
        !cfg2 |-> (row_strobe_copy3_n == sdram_row_strobe_n[0]))
        else $error("dual pin not a row strobe copy");

    a_dual_cfg2: assert property (
        @(posedge sys_clk) disable iff (rst)
        (cfg2 && socket0_hit) |=>
            (row_strobe_copy3_n ==
             primary_mem_addr[dsmo_pkg::COPY_BIT]))
        else $error("dual pin not tracking address bit");

    a_cfg_static: assert property (
        @(posedge sys_clk) disable iff (rst)
        cfg_locked |=> $stable(cfg2))
        else $error("board configuration changed");

    a_we_copies: assert property (
        @(posedge sys_clk) disable iff (rst)
        (s_sdram_act or s_sdram_read) |=> (write_enable_n == '1))
        else $error("write enable copies wrong");

    a_addr_hold: assert property (
        @(posedge sys_clk) disable iff (rst)
        !(is_act || is_col) |=> $stable(primary_mem_addr))
        else $error("address moved without access");

    // sdram command without a column access
    sequence s_sdram_other;
        req_sdram && !is_col;
    endsequence

    // no data moves, so every lane stays masked
    a_idle_masks: assert property (
        @(posedge sys_clk) disable iff (rst)
        s_sdram_other |=> (col_strobe_mask_n == dsmo_pkg::RST_MASK))
        else $error("lanes unmasked without column access");

    // edo write strobe reaches the write enable pins inverted
    a_edo_we: assert property (
        @(posedge sys_clk) disable iff (rst)
        s_edo_req |=> (write_enable_n[0] == !$past(req.edo_we)))
        else $error("edo write strobe wrong");

    // edo rows never see an sdram column strobe
    a_edo_col_idle: assert property (
        @(posedge sys_clk) disable iff (rst)
        s_edo_req |=> logical_col_strobe_n)
        else $error("sdram column strobe during edo access");

    // activate pulls all row copies, dual pin too in cfg1
    a_act_copies: assert property (
        @(posedge sys_clk) disable iff (rst)
        s_sdram_act |=> (sdram_row_strobe_n == '0) &&
                        (cfg2 || !row_strobe_copy3_n))
        else $error("row strobe copies not all active");

    // far-socket accesses with no socket 0 access next leave the dual pin where it was
    a_dual_hold: assert property (
        @(posedge sys_clk) disable iff (rst)
        (cfg2 && !socket0_hit) |=> $stable(row_strobe_copy3_n))
        else $error("dual pin moved on far socket");

endmodule

`default_nettype wire

// [verilog/dsmo_pkg.sv]
// Purpose: shared types and constants for the dram strobe and mask outputs
// Assumes: one sdram clock domain, upstream controller issues one request
//          per cycle already sequenced to sdram timing
// Notes:   command codes are the active-low {row, col, we} strobe levels

`default_nettype none

package dsmo_pkg;

    // pin group widths
    localparam int ADDR_W       = 14;            // multiplexed address lines
    localparam int LANES        = 8;             // strobe / mask byte lanes
    localparam int RAS_COPIES   = 3;             // dedicated row strobe pins
    localparam int WE_COPIES    = 4;             // write enable pins
    localparam int DUP_LANE_A   = 1;             // lane with first duplicate
    localparam int DUP_LANE_B   = 5;             // lane with second duplicate
    localparam int COPY_BIT     = 5;             // address bit on dual pin
    localparam int SOCKET_W     = 2;             // socket number width

    // active-low strobe triples {row, col, we}
    localparam logic [2:0] ENC_NOP   = 3'h7;     // no operation
    localparam logic [2:0] ENC_ACT   = 3'h3;     // open a row
    localparam logic [2:0] ENC_READ  = 3'h5;     // column read
    localparam logic [2:0] ENC_WRITE = 3'h4;     // column write
    localparam logic [2:0] ENC_PRE   = 3'h2;     // close row(s)
    localparam logic [2:0] ENC_REF   = 3'h1;     // auto refresh
    localparam logic [2:0] ENC_MODE  = 3'h0;     // mode register set

    // reset values of the pins
    localparam logic             RST_STROBE = 1'h1;          // strobes idle
    localparam logic [LANES-1:0] RST_MASK   = 8'hFF;         // all masked
    localparam logic [ADDR_W-1:0] RST_ADDR  = 14'h0000;      // address bus
    localparam logic [SOCKET_W-1:0] SOCKET0 = 2'h0;          // near socket

    // memory commands from the sequencer
    typedef enum logic [2:0] {
        DSMO_NOP,
        DSMO_ACT,
        DSMO_READ,
        DSMO_WRITE,
        DSMO_PRE,
        DSMO_REF,
        DSMO_MODE
    } dsmo_cmd_t;

    // one request per clock from the sequencer
    typedef struct packed {
        logic                  valid;        // request present this cycle
        dsmo_cmd_t             cmd;          // command to issue
        logic                  edo_mode;     // 1: target row is edo
        logic [ADDR_W-1:0]     row_addr;     // row address for activate
        logic [ADDR_W-1:0]     col_addr;     // column address for rd/wr
        logic [LANES-1:0]      byte_en;      // sdram lane enables, high=on
        logic [LANES-1:0]      edo_cas;      // edo column strobes, high=on
        logic                  edo_we;       // edo write strobe, high=on
        logic [SOCKET_W-1:0]   socket;       // socket of current access
        logic [SOCKET_W-1:0]   next_socket;  // socket of next access
        logic                  next_valid;   // next_socket is meaningful
    } dsmo_req_t;

endpackage

`default_nettype wire

// [verilog/dsmo_replicate.sv]
// Purpose: registers one logical strobe onto several identical pins
// Assumes: all copies load-share one net, so they must never differ
// Notes:   one flop per copy keeps each pin on its own driver

`timescale 1ns/10ps
`default_nettype none

module dsmo_replicate #(
    parameter int   COPIES = 3,        // number of physical copies
    parameter logic RST_VAL = 1'h1     // idle level of the pin
) (
    input  wire logic              sys_clk,  // sdram clock
    input  wire logic              rst,      // sync reset, active high
    input  wire logic              d,        // next logical level
    output logic [COPIES-1:0]      q         // physical copies
);

    // every copy loads the same next value on the same edge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q <= {COPIES{RST_VAL}};
        end else begin
            q <= {COPIES{d}};
        end
    end

    // copies never disagree after reset
    a_copies_equal: assert property (
        @(posedge sys_clk) disable iff (rst)
        (q == {COPIES{q[0]}}))
        else $error("strobe copies differ");

    // copies follow the input one clock later
    a_copies_follow: assert property (
        @(posedge sys_clk) disable iff (rst)
        ##1 (q[0] == $past(d)))
        else $error("strobe copy did not follow input");

endmodule

`default_nettype wire

// [verilog/dsmo_socket_copy.sv]
// Purpose: address bit copy that moves only when the current or next access is near-socket
// Assumes: enable is computed on the same cycle as the primary address
// Notes:   holds its last value unless the current or next access is near-socket

`timescale 1ns/10ps
`default_nettype none

module dsmo_socket_copy (
    input  wire logic sys_clk,  // sdram clock
    input  wire logic rst,      // sync reset, active high
    input  wire logic en,       // update allowed this edge
    input  wire logic d,        // same next value as primary bit
    output logic      q         // near-socket copy
);

    // load with the primary bit, otherwise keep the old level
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q <= 1'h0;
        end else if (en) begin
            q <= d;
        end
    end

    // far-socket accesses with no near-socket access next leave the copy untouched
    a_copy_hold: assert property (
        @(posedge sys_clk) disable iff (rst)
        !en |=> $stable(q))
        else $error("address copy moved on far socket");

    // near-socket accesses track the primary bit on the same edge
    a_copy_update: assert property (
        @(posedge sys_clk) disable iff (rst)
        en |=> (q == $past(d)))
        else $error("address copy missed update");

endmodule

`default_nettype wire
